// >>> src/ufb_defs.svh
// Register offsets, bit positions, reset values and counts for the frame/baud block
`ifndef UFB_DEFS_SVH
`define UFB_DEFS_SVH
`define UFB_A_STAT 4'h0
`define UFB_A_CTLB 4'h1
`define UFB_A_DATA 4'h2
`define UFB_A_SHARED 4'h3
`define UFB_A_BDHI 4'h4
`define UFB_A_BDLO 4'h5
`define UFB_A_ISTAT 4'h6
`define UFB_A_ICLR 4'h7
`define UFB_A_IEN 4'h8
`define UFB_SEL_BIT 7
`define UFB_PE_BIT 2
`define UFB_DBL_BIT 1
`define UFB_CSZH_BIT 2
`define UFB_RXB8_BIT 1
`define UFB_TXB8_BIT 0
`define UFB_EV_TX 0
`define UFB_EV_RX 1
`define UFB_EV_PE 2
`define UFB_C_RESET 7'h03
`define UFB_OS_NORM 4'hf
`define UFB_OS_DBL 4'h7
`define UFB_MID_NORM 4'h7
`define UFB_MID_DBL 4'h3
`endif

// >>> src/ufb_pkg.sv
// Types of the frame-format and baud configuration block
package ufb_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_STOP2, TX_END} ufb_tx_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufb_rx_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } ufb_bus_t;
    typedef struct packed {
        logic sync;
        logic [1:0] pm;
        logic sbs;
        logic [1:0] csz;
        logic pol;
    } ufb_fc_t;
    typedef struct packed {
        ufb_tx_t tx_st;
        ufb_rx_t rx_st;
        ufb_fc_t fc;
        logic [3:0] bd_hi;
        logic [7:0] bd_lo;
        logic dbl;
        logic csz_hi;
        logic tx_b8;
        logic rx_b8;
        logic [11:0] pre;
        logic transfer_clock_pin;
        logic [3:0] tx_os;
        logic [8:0] tx_sh;
        logic [3:0] tx_cnt;
        logic tx_par;
        logic txd;
        logic rx_s1;
        logic rx_s2;
        logic [3:0] rx_os;
        logic [8:0] rx_sh;
        logic [3:0] rx_cnt;
        logic rx_par;
        logic [7:0] rx_data;
        logic pe;
        logic [2:0] ist;
        logic [2:0] ien;
        logic [7:0] rdata;
    } ufb_st_t;
endpackage

// >>> src/ufb_top.sv
// Serial transceiver with frame-format and baud-rate configuration registers
//
// Function
// R1: Transmitter inserts computed parity bit automatically
// R2: Parity field: off, reserved, even, odd
// R3: Receiver flags parity mismatch in status A
// R4: Stop select gives one or two stop bits
// R5: Receiver ignores stop bit select setting
// R6: Character size 5..8 or 9 data bits
// R7: Software keeps polarity zero in async mode
// R8: Polarity picks transmit change and sample edges
// R9: Divisor high shares location, top bit zero
// R10: Software writes divisor high reserved bits zero
// R11: Divisor is twelve bits, high and low
// R12: Software avoids divisor change mid frame
// R13: Low divisor write reloads prescaler at once
// R14: Software judges baud error below half percent
// R15: Async divides by 16, or 8 doubled
// R16: Register C reads top bit one, selects
// R17: Mode bit: zero async, one sync
// R18: Prescaler counts down, ticks every divisor+1
// R19: Reserved codes stored unchanged, behaviour undefined
`timescale 1ns/1ps
`include "ufb_defs.svh"
module ufb_top (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Register port
    input ufb_pkg::ufb_bus_t i_bus,
    output logic [7:0] o_rdata,
    // Serial pins
    output logic o_txd,
    input wire logic i_rxd,
    output logic o_xck_out,
    output logic o_xck_oe,
    // Interrupt
    output logic o_irq
);
    import ufb_pkg::*;

    ufb_st_t s_q;
    ufb_st_t s_d;
    logic tick;
    logic rise;
    logic fall;
    logic tx_bit;
    logic rx_smp;
    logic pen;
    logic [3:0] nb;
    logic [3:0] top;
    logic [3:0] mid;
    logic [8:0] rx_word;

    ////////////////////////////////////////////////////////////////////////////
    // Timing terms
    assign pen = s_q.fc.pm[1]; // [R2]
    assign nb = s_q.csz_hi ? 4'h9 : {2'h0, s_q.fc.csz} + 4'h5; // [R6] [R19]
    // Double speed only shortens the async oversampling period
    assign top = (s_q.dbl && !s_q.fc.sync) ? `UFB_OS_DBL : `UFB_OS_NORM; // [R15]
    assign mid = (s_q.dbl && !s_q.fc.sync) ? `UFB_MID_DBL : `UFB_MID_NORM; // [R15]
    assign tick = (s_q.pre == 12'h000); // [R18]
    assign rise = s_q.fc.sync && tick && !s_q.transfer_clock_pin;
    assign fall = s_q.fc.sync && tick && s_q.transfer_clock_pin;
    assign tx_bit = s_q.fc.sync ? (s_q.fc.pol ? fall : rise) : (tick && s_q.tx_os == top); // [R8] [R17]
    assign rx_smp = s_q.fc.sync ? (s_q.fc.pol ? rise : fall) : (tick && s_q.rx_os == mid); // [R8] [R17]
    assign rx_word = s_q.rx_sh >> (4'h9 - nb); // [R6]

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [2:0] ev;
        logic [2:0] clr;
        logic [7:0] r;
        ev = 3'h0;
        clr = 3'h0;
        r = 8'h00;
        s_d = s_q;
        s_d.rx_s1 = i_rxd;
        s_d.rx_s2 = s_q.rx_s1;

        // Prescaler and transfer clock
        s_d.pre = tick ? {s_q.bd_hi, s_q.bd_lo} : s_q.pre - 12'h001; // [R18] [R11]
        if (!s_q.fc.sync) begin
            s_d.transfer_clock_pin = 1'b0; // [R17]
        end else if (tick) begin
            s_d.transfer_clock_pin = ~s_q.transfer_clock_pin;
        end
        if (tick && !s_q.fc.sync) begin
            s_d.tx_os = (s_q.tx_os == top) ? 4'h0 : s_q.tx_os + 4'h1; // [R15]
        end

        // Transmitter
        if (tx_bit) begin
            case (s_q.tx_st)
                TX_START: begin
                    s_d.txd = 1'b0;
                    s_d.tx_st = TX_DATA;
                end
                TX_DATA: begin
                    s_d.txd = s_q.tx_sh[0];
                    s_d.tx_par = s_q.tx_par ^ s_q.tx_sh[0]; // [R1]
                    s_d.tx_sh = {1'b0, s_q.tx_sh[8:1]};
                    s_d.tx_cnt = s_q.tx_cnt + 4'h1;
                    if (s_q.tx_cnt == nb - 4'h1) begin // [R6]
                        s_d.tx_st = pen ? TX_PAR : TX_STOP; // [R1] [R2]
                    end
                end
                TX_PAR: begin
                    s_d.txd = s_q.tx_par ^ s_q.fc.pm[0]; // [R1] [R2]
                    s_d.tx_st = TX_STOP;
                end
                TX_STOP: begin
                    s_d.txd = 1'b1;
                    s_d.tx_st = s_q.fc.sbs ? TX_STOP2 : TX_END; // [R4]
                end
                TX_STOP2: begin
                    s_d.txd = 1'b1;
                    s_d.tx_st = TX_END;
                end
                TX_END: begin
                    s_d.tx_st = TX_IDLE;
                    ev[`UFB_EV_TX] = 1'b1;
                end
                default: begin
                    s_d.txd = 1'b1;
                end
            endcase
        end

        // Receiver
        if (tick && !s_q.fc.sync && s_q.rx_st != RX_IDLE) begin
            s_d.rx_os = (s_q.rx_os == top) ? 4'h0 : s_q.rx_os + 4'h1;
        end
        case (s_q.rx_st)
            RX_IDLE: begin
                s_d.rx_par = 1'b0;
                s_d.rx_cnt = 4'h0;
                if (s_q.fc.sync && rx_smp && !s_q.rx_s2) begin
                    s_d.rx_st = RX_DATA;
                end else if (!s_q.fc.sync && tick && !s_q.rx_s2) begin
                    s_d.rx_st = RX_START;
                    s_d.rx_os = 4'h0;
                end
            end
            RX_START: begin
                // A start bit gone high at mid-bit was a glitch
                if (rx_smp) begin
                    s_d.rx_st = s_q.rx_s2 ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_smp) begin
                    s_d.rx_sh = {s_q.rx_s2, s_q.rx_sh[8:1]};
                    s_d.rx_par = s_q.rx_par ^ s_q.rx_s2; // [R3]
                    s_d.rx_cnt = s_q.rx_cnt + 4'h1;
                    if (s_q.rx_cnt == nb - 4'h1) begin // [R6]
                        s_d.rx_st = pen ? RX_PAR : RX_STOP; // [R2]
                    end
                end
            end
            RX_PAR: begin
                if (rx_smp) begin
                    s_d.rx_par = s_q.rx_par ^ s_q.rx_s2; // [R3]
                    s_d.rx_st = RX_STOP;
                end
            end
            RX_STOP: begin
                // Only the first stop bit is looked at, whatever the stop select says
                if (rx_smp) begin // [R5]
                    s_d.rx_st = RX_IDLE;
                    s_d.rx_data = rx_word[7:0];
                    s_d.rx_b8 = rx_word[8];
                    s_d.pe = pen && (s_q.rx_par != s_q.fc.pm[0]); // [R3]
                    ev[`UFB_EV_RX] = 1'b1;
                    ev[`UFB_EV_PE] = pen && (s_q.rx_par != s_q.fc.pm[0]); // [R3]
                end
            end
            default: begin
                s_d.rx_st = RX_IDLE;
            end
        endcase

        // Register writes
        if (i_bus.we) begin
            case (i_bus.addr)
                `UFB_A_STAT: s_d.dbl = i_bus.wdata[`UFB_DBL_BIT];
                `UFB_A_CTLB: begin
                    s_d.csz_hi = i_bus.wdata[`UFB_CSZH_BIT]; // [R19]
                    s_d.tx_b8 = i_bus.wdata[`UFB_TXB8_BIT];
                end
                `UFB_A_DATA: begin
                    // Writes while a frame is in flight are dropped
                    if (s_q.tx_st == TX_IDLE) begin
                        s_d.tx_st = TX_START;
                        s_d.tx_sh = {s_q.tx_b8, i_bus.wdata};
                        s_d.tx_cnt = 4'h0;
                        s_d.tx_par = 1'b0;
                        s_d.tx_os = 4'h0;
                    end
                end
                `UFB_A_SHARED: begin
                    if (i_bus.wdata[`UFB_SEL_BIT]) begin
                        s_d.fc = i_bus.wdata[6:0]; // [R16] [R19]
                    end else begin
                        s_d.bd_hi = i_bus.wdata[3:0]; // [R9] [R11]
                    end
                end
                `UFB_A_BDLO: begin
                    s_d.bd_lo = i_bus.wdata;
                    s_d.pre = {s_q.bd_hi, i_bus.wdata}; // [R13] [R11]
                end
                `UFB_A_ICLR: clr = i_bus.wdata[2:0];
                `UFB_A_IEN: s_d.ien = i_bus.wdata[2:0];
                default: begin
                end
            endcase
        end
        // A new event wins over a clear in the same cycle
        s_d.ist = (s_q.ist & ~clr) | ev;

        // Register reads
        case (i_bus.addr)
            `UFB_A_STAT: begin
                r[`UFB_PE_BIT] = s_q.pe; // [R3]
                r[`UFB_DBL_BIT] = s_q.dbl;
            end
            `UFB_A_CTLB: begin
                r[`UFB_CSZH_BIT] = s_q.csz_hi;
                r[`UFB_RXB8_BIT] = s_q.rx_b8;
                r[`UFB_TXB8_BIT] = s_q.tx_b8;
            end
            `UFB_A_DATA: r = s_q.rx_data;
            `UFB_A_SHARED: r = {1'b1, s_q.fc}; // [R16]
            `UFB_A_BDHI: r = {4'h0, s_q.bd_hi}; // [R9]
            `UFB_A_BDLO: r = s_q.bd_lo;
            `UFB_A_ISTAT: r = {5'h00, s_q.ist};
            `UFB_A_IEN: r = {5'h00, s_q.ien};
            default: r = 8'h00;
        endcase
        s_d.rdata = i_bus.re ? r : 8'h00;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            s_q <= '0;
            s_q.fc <= `UFB_C_RESET;
            s_q.txd <= 1'b1;
            s_q.rx_s1 <= 1'b1;
            s_q.rx_s2 <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_rdata = s_q.rdata;
    assign o_txd = s_q.txd;
    // Master-only transfer clock; it drives the pin only in sync mode
    assign o_xck_out = s_q.transfer_clock_pin;
    assign o_xck_oe = s_q.fc.sync; // [R17]
    assign o_irq = |(s_q.ist & s_q.ien);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    property p_r13;
        (i_bus.we && i_bus.addr == `UFB_A_BDLO) |=> s_q.pre == {s_q.bd_hi, $past(i_bus.wdata)};
    endproperty
    a_r13: assert property (p_r13) else $error("prescaler not reloaded by low write"); // [R13]

    property p_r18;
        (!tick && !(i_bus.we && i_bus.addr == `UFB_A_BDLO)) |=> s_q.pre == $past(s_q.pre) - 12'h001;
    endproperty
    a_r18: assert property (p_r18) else $error("prescaler did not count down"); // [R18]

    property p_r9;
        (i_bus.re && i_bus.addr == `UFB_A_BDHI) |=> o_rdata == {4'h0, $past(s_q.bd_hi)};
    endproperty
    a_r9: assert property (p_r9) else $error("divisor high read wrong"); // [R9]

    property p_r16;
        (i_bus.we && i_bus.addr == `UFB_A_SHARED && !i_bus.wdata[7]) |=> $stable(s_q.fc) ##1 1'b1;
    endproperty
    a_r16: assert property (p_r16) else $error("select zero write reached register C"); // [R16]

    property p_r4;
        (s_q.tx_st == TX_STOP && tx_bit && !s_q.fc.sbs) |=> s_q.tx_st == TX_END;
    endproperty
    a_r4: assert property (p_r4) else $error("extra stop bit sent"); // [R4]

    property p_r1;
        (s_q.tx_st == TX_PAR && tx_bit) |=> o_txd == $past(s_q.tx_par ^ s_q.fc.pm[0]);
    endproperty
    a_r1: assert property (p_r1) else $error("parity bit wrong"); // [R1]

    property p_r2;
        (s_q.tx_st == TX_PAR || s_q.rx_st == RX_PAR) |-> s_q.fc.pm[1];
    endproperty
    a_r2: assert property (p_r2) else $error("parity phase without parity enabled"); // [R2]

    property p_r6;
        (s_q.tx_st == TX_DATA && tx_bit && s_q.tx_cnt == nb - 4'h1) |=> s_q.tx_st != TX_DATA;
    endproperty
    a_r6: assert property (p_r6) else $error("data bit count wrong"); // [R6]

    property p_r3;
        (s_q.rx_st == RX_STOP && rx_smp) |=> s_q.pe == $past(pen && (s_q.rx_par != s_q.fc.pm[0]));
    endproperty
    a_r3: assert property (p_r3) else $error("parity error flag wrong"); // [R3]

    property p_r8;
        (s_q.fc.sync && $stable(s_q.fc) && $changed(o_txd)) |-> (s_q.fc.pol ? $fell(o_xck_out) : $rose(o_xck_out));
    endproperty
    a_r8: assert property (p_r8) else $error("transmit data changed on wrong edge"); // [R8]

    property p_r15;
        (!s_q.fc.sync && tick && s_q.tx_os == top) |=> s_q.tx_os == 4'h0;
    endproperty
    a_r15: assert property (p_r15) else $error("oversampling wrap wrong"); // [R15]

    c_par_frame: cover property (s_q.tx_st == TX_PAR ##[1:1000] s_q.tx_st == TX_END);
    c_rx_done: cover property (s_q.rx_st == RX_STOP ##1 s_q.rx_st == RX_IDLE);
    c_sync_tx: cover property (s_q.fc.sync && s_q.tx_st == TX_DATA);
    c_irq: cover property ($rose(o_irq));
endmodule // ufb_top

// >>> dv/ufb_peer.sv
// Behavioural remote serial peer: frame capture on transmit, frame injection on receive
`timescale 1ns/1ps
module ufb_peer (
    // Clock
    input wire logic i_clk_sys,
    // Serial lines
    input wire logic i_txd,
    input wire logic i_xck,
    output logic o_rxd
);
    int cyc = 0;

    initial o_rxd = 1'b1;

    always @(posedge i_clk_sys) cyc <= cyc + 1;

    ////////////////////////////////////////
    // Bit period equals the block's own, so the rate error stays at zero
    task automatic send(input logic [31:0] bits, input int n, input int t);
        for (int i = 0; i < n; i++) begin
            o_rxd <= bits[i];
            repeat (t) @(posedge i_clk_sys);
        end
        o_rxd <= 1'b1;
    endtask

    ////////////////////////////////////////
    // Samples mid-bit on falling edges, away from the launch edge; returns at the last sample.
    // A missing start gives t0 = -1, so the caller can stop the run.
    task automatic grab(input int n, input int t, output logic [15:0] bits, output int t0);
        int w;
        w = 0;
        bits = '1;
        while (i_txd !== 1'b0 && w < 20000) begin
            @(negedge i_clk_sys);
            w++;
        end
        t0 = (i_txd === 1'b0) ? cyc : -1;
        repeat (t / 2) @(negedge i_clk_sys);
        for (int i = 0; i < n; i++) begin
            bits[i] = i_txd;
            if (i < n - 1) repeat (t) @(negedge i_clk_sys);
        end
    endtask

    ////////////////////////////////////////
    // Clocked mode: each bit goes out just after the block's transmit-change edge
    task automatic sync_send(input logic [15:0] bits, input int n, input logic pol, output logic ok);
        logic p;
        int w;
        ok = 1'b1;
        for (int i = 0; i < n; i++) begin
            w = 0;
            @(negedge i_clk_sys);
            p = i_xck;
            @(negedge i_clk_sys);
            while (!(i_xck !== p && i_xck === ~pol) && w < 2000) begin
                p = i_xck;
                @(negedge i_clk_sys);
                w++;
            end
            if (w == 2000) ok = 1'b0;
            o_rxd <= bits[i];
        end
    endtask
endmodule // ufb_peer

// >>> dv/tb_uart_frame_format_and_baud_config.sv
// Self-checking bench for the frame-format and baud configuration block
`timescale 1ns/1ps
module tb_uart_frame_format_and_baud_config;
    import ufb_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    ufb_bus_t bus = '0;
    logic [7:0] o_rdata;
    logic o_txd;
    logic o_xck_out;
    logic o_xck_oe;
    logic o_irq;
    logic rxd;
    int miscompares = 0;
    int checks_done = 0;

    always #2.5 i_clk_sys = ~i_clk_sys;

    ufb_top ufb_top_inst (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_bus(bus), .o_rdata(o_rdata),
        .o_txd(o_txd), .i_rxd(rxd), .o_xck_out(o_xck_out), .o_xck_oe(o_xck_oe), .o_irq(o_irq));
    ufb_peer ufb_peer_inst (.i_clk_sys(i_clk_sys), .i_txd(o_txd), .i_xck(o_xck_out), .o_rxd(rxd));

    ////////////////////////////////////////
    task automatic stop_test();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    // Strobe then a quiet cycle, so no signal is assigned twice in one time step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge i_clk_sys);
        bus <= '0;
        @(posedge i_clk_sys);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge i_clk_sys);
        bus <= '0;
        @(negedge i_clk_sys);
        d = o_rdata;
        @(posedge i_clk_sys);
    endtask

    task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(n, e, v);
    endtask

    // Start, data LSB first, optional parity; everything above stays idle high
    function automatic logic [15:0] frame(input logic [8:0] d, input int nb, input logic [1:0] pm);
        logic [15:0] f;
        logic p;
        f = '1;
        f[0] = 1'b0;
        p = pm[0];
        for (int i = 0; i < nb; i++) begin
            f[1 + i] = d[i];
            p ^= d[i];
        end
        if (pm[1]) f[1 + nb] = p;
        return f;
    endfunction

    ////////////////////////////////////////
    task automatic t_regs();
        chk("reset pins", 16'h0001, {o_xck_out, o_xck_oe, o_irq, o_txd});
        rc("reg c reset", 4'h3, 8'h83);
        rc("div high reset", 4'h4, 8'h00);
        rc("unmapped", 4'hf, 8'h00);
        wr(4'h3, 8'h0a);
        rc("div high", 4'h4, 8'h0a);
        rc("reg c kept", 4'h3, 8'h83);
        wr(4'h3, 8'h9c);
        rc("reserved parity kept", 4'h3, 8'h9c);
        wr(4'h8, 8'h05);
        rc("int enable", 4'h8, 8'h05);
        wr(4'h8, 8'h00);
        wr(4'h3, 8'h00);
        wr(4'h5, 8'h01);
    endtask

    task automatic t_tx(input int nb, input logic [1:0] pm, input logic sbs, input logic dbl, input logic [8:0] d);
        logic [15:0] got;
        logic [2:0] c;
        int t;
        int len;
        int t0;
        int n;
        int el;
        c = (nb == 9) ? 3'h7 : 3'(nb - 5);
        t = dbl ? 16 : 32;
        len = 1 + nb + int'(pm[1]);
        wr(4'h3, {1'b1, 1'b0, pm, sbs, c[1:0], 1'b0});
        wr(4'h1, {5'h00, c[2], 1'b0, d[8]});
        wr(4'h0, {6'h00, dbl, 1'b0});
        wr(4'h8, 8'h01);
        wr(4'h7, 8'h07);
        wr(4'h2, d[7:0]);
        ufb_peer_inst.grab(len + 1, t, got, t0);
        if (t0 < 0) begin
            chk("tx start wait", 16'h0001, 16'h0000);
            stop_test();
        end
        chk("tx bits", frame(d, nb, pm), got);
        // Watch the interrupt pin every cycle, so the frame length is timed to the clock
        n = 0;
        while (o_irq !== 1'b1 && n < 400) begin
            @(negedge i_clk_sys);
            n++;
        end
        if (n == 400) begin
            chk("tx done wait", 16'h0001, 16'h0000);
            stop_test();
        end
        el = ufb_peer_inst.cyc - t0;
        n = (len + 1 + int'(sbs)) * t;
        chk("tx frame time", 16'h0001, 16'((el >= n - 6) && (el <= n + 6)));
        @(posedge i_clk_sys);
        rc("tx done status", 4'h6, 8'h01);
    endtask

    task automatic t_rx();
        logic [15:0] f1;
        logic [15:0] f2;
        logic [7:0] v;
        wr(4'h3, 8'hae);
        // The nine-bit size left by the transmit tests must not leak into these frames
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h00);
        wr(4'h8, 8'h02);
        wr(4'h7, 8'h07);
        f1 = frame(9'h03c, 8, 2'b10);
        f1[9] = ~f1[9];
        f2 = frame(9'h081, 8, 2'b10);
        // One stop only between frames although two are configured
        ufb_peer_inst.send({10'h3ff, f2[10:0], f1[10:0]}, 22, 32);
        repeat (8) @(posedge i_clk_sys);
        chk("irq raised", 16'h0001, o_irq);
        rc("rx data", 4'h2, 8'h81);
        rc("int status", 4'h6, 8'h06);
        rd(4'h0, v);
        chk("parity flag clean", 16'h0000, v[2]);
        wr(4'h7, 8'h07);
        chk("irq cleared", 16'h0000, o_irq);
        wr(4'h8, 8'h00);
        ufb_peer_inst.send({21'h1fffff, f1[10:0]}, 11, 32);
        repeat (8) @(posedge i_clk_sys);
        rd(4'h0, v);
        chk("parity flag set", 16'h0001, v[2]);
        chk("irq masked", 16'h0000, o_irq);
        rc("int status masked", 4'h6, 8'h06);
    endtask

    task automatic t_sync(input logic pol);
        logic px;
        logic pt;
        logic ok;
        int last;
        wr(4'h3, 8'h01);
        wr(4'h5, 8'h02);
        wr(4'h3, {7'h63, pol});
        chk("xck enable", 16'h0001, o_xck_oe);
        wr(4'h2, 8'h96);
        @(negedge i_clk_sys);
        px = o_xck_out;
        pt = o_txd;
        last = -1;
        for (int k = 0; k < 7000; k++) begin
            @(negedge i_clk_sys);
            if (o_xck_out !== px && last >= 0) chk("xck half period", 16'd259, 16'(k - last));
            if (o_xck_out !== px) last = k;
            if (o_txd !== pt) chk("txd edge", {1'b1, ~pol}, {o_xck_out !== px, o_xck_out});
            px = o_xck_out;
            pt = o_txd;
        end
        @(posedge i_clk_sys);
        // Clocked receive: the data byte differs per polarity, so a stale byte cannot pass
        ufb_peer_inst.sync_send(frame({1'b0, 7'h2d, pol}, 8, 2'b00), 10, pol, ok);
        if (!ok) begin
            chk("sync clock wait", 16'h0001, 16'h0000);
            stop_test();
        end
        repeat (600) @(posedge i_clk_sys);
        rc("sync rx data", 4'h2, {7'h2d, pol});
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        @(posedge i_clk_sys);
        t_regs();
        t_tx(5, 2'b00, 1'b0, 1'b0, 9'h015);
        t_tx(6, 2'b11, 1'b1, 1'b1, 9'h02d);
        t_tx(7, 2'b10, 1'b1, 1'b0, 9'h05a);
        t_tx(8, 2'b11, 1'b0, 1'b1, 9'h0c3);
        t_tx(9, 2'b10, 1'b1, 1'b0, 9'h1a5);
        t_rx();
        t_sync(1'b0);
        t_sync(1'b1);
        stop_test();
    end
endmodule // tb_uart_frame_format_and_baud_config
